// File: hw/fpm_mapper.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [R1] address 0 or above 125 lights error
// [R2] integrator keeps addresses unique, above 2
// [R3] bus clear zeroes or holds outputs
// [R4] conventional layout only when map is 1
// [R5] address, map, index size need power cycle
// [R6] initialise resets comm settings if enabled
// [R7] image is 32, 12 or 6 bytes
// [R8] split image into fast and message bytes
// [R9] fast data reaches drive within 2 ms
// [R10] master paces messages by handshake
// [R11] output image: command, frequency, torque, high first
// [R12] input image: status, speed, current, high first
// [R13] torque word gated by mode and enable
// [R14] current in 0.01 A or 0.1 A
// [R15] speed word follows display scaling
// [R16] network run and reference need source 3
// [R17] external fault method 3 only alarms
// [R18] bus error applies selected stop response
// [R19] reserved bytes ignored, returned as zero
module fpm_mapper #(
   parameter int unsigned FAST_LIMIT = fpm_pkg::FAST_LIMIT_CYC
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   // register port
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [15:0] reg_wdata_i,
   input  wire logic        reg_we_i,
   input  wire logic        reg_re_i,
   output logic [15:0]      reg_rdata_o,
   // power supervisor
   input  wire logic        power_up_i,
   // fieldbus images
   input  wire logic [1:0]  img_len_i,
   input  wire logic        rx_valid_i,
   input  wire logic [7:0]  rx_byte_i,
   input  wire logic        rx_last_i,
   input  wire logic        clear_cmd_i,
   input  wire logic        tx_rd_i,
   input  wire logic [4:0]  tx_idx_i,
   output logic [7:0]       tx_byte_o,
   // register messages
   output logic             msg_valid_o,
   output logic [3:0]       msg_idx_o,
   output logic [7:0]       msg_byte_o,
   input  wire logic        rsp_we_i,
   input  wire logic [3:0]  rsp_idx_i,
   input  wire logic [7:0]  rsp_byte_i,
   // drive commands
   output logic [15:0]      op_cmd_o,
   output logic             net_run_en_o,
   output logic [15:0]      freq_ref_o,
   output logic             net_freq_en_o,
   output logic [15:0]      torque_ref_o,
   output logic             torque_ref_en_o,
   output logic [15:0]      torque_lim_o,
   output logic             torque_lim_en_o,
   // drive monitors
   input  wire logic [15:0] drive_status_i,
   input  wire logic [15:0] speed_freq_i,
   input  wire logic [15:0] speed_user_i,
   input  wire logic [15:0] current_i,
   input  wire logic        drive_large_i,
   // faults and indicators
   input  wire logic        ext_fault_i,
   input  wire logic        bus_err_i,
   output logic             stop_req_o,
   output logic [1:0]       stop_mode_o,
   output logic             alarm_o,
   output logic             err_led_o,
   output logic             irq_o
);
   // image geometry
   function automatic logic [4:0] last_of(input logic [1:0] len);
      case (len)
         fpm_pkg::LEN_EXT1:  last_of = fpm_pkg::LAST_EXT1;
         fpm_pkg::LEN_EXT2:  last_of = fpm_pkg::LAST_EXT2;
         default:            last_of = fpm_pkg::LAST_BASIC;
      endcase
   endfunction
   function automatic logic [4:0] msg_of(input logic [1:0] len);
      msg_of = (len == fpm_pkg::LEN_EXT1) ? fpm_pkg::MSG_EXT1 : fpm_pkg::MSG_EXT2;
   endfunction
   function automatic logic [15:0] put(input logic [15:0] w, input logic lo, input logic [7:0] b);
      put = lo ? {w[15:8], b} : {b, w[7:0]};
   endfunction
   function automatic logic [7:0] pick(input logic [15:0] w, input logic lo);
      pick = lo ? w[7:0] : w[15:8];
   endfunction

   // settings and status
   logic [15:0]          comm;
   logic [15:0]          drv;
   logic [fpm_pkg::S_W-1:0] stat;
   logic [fpm_pkg::S_W-1:0] mask;
   logic [15:0]          next_comm;
   logic [15:0]          next_drv;
   logic [fpm_pkg::S_W-1:0] next_stat;
   logic [fpm_pkg::S_W-1:0] next_mask;
   logic [15:0]          next_rdata;
   logic                 fault_clr;
   logic [fpm_pkg::S_W-1:0] evt;
   // power-up copies
   logic [6:0]           act_addr;
   logic                 act_map;
   logic                 act_idx;
   logic                 next_led;
   // frame parser
   logic [4:0]           rx_idx;
   logic [15:0]          stg_op;
   logic [15:0]          stg_freq;
   logic [15:0]          stg_trq;
   logic                 pend;
   logic [17:0]          wait_cnt;
   logic [15:0]          hold_op;
   logic [15:0]          hold_freq;
   logic [15:0]          hold_trq;
   logic [4:0]           next_rx_idx;
   logic [15:0]          next_stg_op;
   logic [15:0]          next_stg_freq;
   logic [15:0]          next_stg_trq;
   logic                 next_pend;
   logic [17:0]          next_wait;
   logic [15:0]          next_hold_op;
   logic [15:0]          next_hold_freq;
   logic [15:0]          next_hold_trq;
   logic                 next_msg_valid;
   logic [3:0]           next_msg_idx;
   logic                 len_ok;
   logic [4:0]           fast_last;
   logic [4:0]           msg_off;
   // answer image
   logic [7:0]           rsp_mem [16];
   logic [7:0]           next_tx;
   logic [15:0]          spd_word;
   logic [15:0]          cur_word;
   logic [4:0]           tx_rel;
   // torque gating and fault responses
   logic                 trq_use;
   logic                 trq_lim;
   logic [2:0]           cm;
   logic                 stop_b;
   logic                 stop_e;
   logic                 alm_b;
   logic                 alm_e;
   logic [1:0]           mode_b;
   logic [1:0]           mode_e;

   assign cm = drv[fpm_pkg::F_CM +: 3];

   // register writes, initialise, sticky status
   always_comb begin
      next_comm = comm;
      next_drv  = drv;
      next_mask = mask;
      next_stat = stat;
      fault_clr = 1'b0;
      if (reg_we_i) begin
         if (reg_addr_i == fpm_pkg::A_COMM) begin
            next_comm = reg_wdata_i;
         end else if (reg_addr_i == fpm_pkg::A_DRIVE) begin
            next_drv = reg_wdata_i;
         end else if (reg_addr_i == fpm_pkg::A_CMD) begin
            if (reg_wdata_i[0]) begin
               next_drv = fpm_pkg::DRIVE_RST;
               if (comm[fpm_pkg::F_CRST]) begin
                  next_comm = fpm_pkg::COMM_RST; // R6
               end
            end
            fault_clr = reg_wdata_i[1];
         end else if (reg_addr_i == fpm_pkg::A_STAT) begin
            next_stat = stat & ~reg_wdata_i[fpm_pkg::S_W-1:0];
         end else if (reg_addr_i == fpm_pkg::A_MASK) begin
            next_mask = reg_wdata_i[fpm_pkg::S_W-1:0];
         end
      end
      next_stat = next_stat | evt;
   end

   // read data, one cycle after the strobe only
   always_comb begin
      next_rdata = 16'h0000;
      if (reg_re_i) begin
         if (reg_addr_i == fpm_pkg::A_COMM) begin
            next_rdata = comm;
         end else if (reg_addr_i == fpm_pkg::A_DRIVE) begin
            next_rdata = drv;
         end else if (reg_addr_i == fpm_pkg::A_STAT) begin
            next_rdata = {10'h000, stat};
         end else if (reg_addr_i == fpm_pkg::A_MASK) begin
            next_rdata = {10'h000, mask};
         end else if (reg_addr_i == fpm_pkg::A_ACTIVE) begin
            next_rdata = {stop_mode_o, alarm_o, stop_req_o, err_led_o, act_idx, act_map, 2'h0, act_addr};
         end
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         comm        <= fpm_pkg::COMM_RST;
         drv         <= fpm_pkg::DRIVE_RST;
         stat        <= '0;
         mask        <= '0;
         reg_rdata_o <= 16'h0000;
         irq_o       <= 1'b0;
      end else begin
         comm        <= next_comm;
         drv         <= next_drv;
         stat        <= next_stat;
         mask        <= next_mask;
         reg_rdata_o <= next_rdata;
         irq_o       <= |(next_stat & next_mask);
      end
   end

   // settings copied only at power up
   assign next_led = (comm[6:0] == 7'h00) || (comm[6:0] > fpm_pkg::ADDR_MAX);
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         act_addr  <= 7'h00;
         act_map   <= 1'b0;
         act_idx   <= 1'b0;
         err_led_o <= 1'b0;
      end else if (power_up_i) begin
         act_addr  <= comm[6:0]; // R5
         act_map   <= comm[fpm_pkg::F_MAP];
         act_idx   <= comm[fpm_pkg::F_IDX];
         err_led_o <= next_led; // R1
      end
   end

   // events into status
   always_comb begin
      evt                 = '0;
      evt[fpm_pkg::S_CLEAR] = clear_cmd_i;
      evt[fpm_pkg::S_BUS]   = bus_err_i;
      evt[fpm_pkg::S_EXT]   = ext_fault_i;
      evt[fpm_pkg::S_ADDR]  = power_up_i & next_led;
      evt[fpm_pkg::S_FRAME] = rx_valid_i & rx_last_i & len_ok & act_map & (rx_idx == last_of(img_len_i));
      evt[fpm_pkg::S_LEN]   = rx_valid_i & ~len_ok;
      evt[fpm_pkg::S_LEN]   = evt[fpm_pkg::S_LEN] | (rx_valid_i & rx_last_i & (rx_idx != last_of(img_len_i)));
   end

   // image geometry for the configured length
   assign len_ok    = (img_len_i != 2'h3) && (rx_idx <= last_of(img_len_i)); // R7
   assign msg_off   = msg_of(img_len_i);
   assign fast_last = (img_len_i == fpm_pkg::LEN_EXT1) ? fpm_pkg::FAST_EXT1 :
                      (img_len_i == fpm_pkg::LEN_EXT2) ? fpm_pkg::FAST_EXT2 : fpm_pkg::LAST_BASIC;

   // output image parser and fast-data transfer
   always_comb begin
      next_rx_idx    = rx_idx;
      next_stg_op    = stg_op;
      next_stg_freq  = stg_freq;
      next_stg_trq   = stg_trq;
      next_pend      = pend;
      next_wait      = wait_cnt;
      next_hold_op   = hold_op;
      next_hold_freq = hold_freq;
      next_hold_trq  = hold_trq;
      next_msg_valid = 1'b0;
      next_msg_idx   = msg_idx_o;
      if (pend) begin
         next_wait = wait_cnt + 18'h00001;
      end
      if (rx_valid_i) begin
         next_rx_idx = rx_last_i ? 5'h00 : rx_idx + 5'h01;
         if (len_ok && act_map) begin // R4
            if (rx_idx <= fast_last) begin // R8
               if (rx_idx[4:1] == fpm_pkg::B_OP[4:1]) begin
                  next_stg_op = put(stg_op, rx_idx[0], rx_byte_i); // R11
               end else if (rx_idx[4:1] == fpm_pkg::B_FREQ[4:1]) begin
                  next_stg_freq = put(stg_freq, rx_idx[0], rx_byte_i);
               end else if (rx_idx[4:1] == fpm_pkg::B_TRQ[4:1]) begin
                  next_stg_trq = put(stg_trq, rx_idx[0], rx_byte_i);
               end
               if (rx_idx == fast_last) begin
                  next_pend = 1'b1;
                  next_wait = 18'h00000;
               end
            end else begin
               next_msg_valid = 1'b1; // R8
               next_msg_idx   = 4'(rx_idx - msg_off);
            end
         end
         if (rx_last_i && rx_idx != last_of(img_len_i)) begin
            next_pend = 1'b0;
         end
      end
      // frame end or deadline moves fast data to the drive
      if (next_pend && ((rx_valid_i && rx_last_i) || wait_cnt >= 18'(FAST_LIMIT - 1))) begin
         next_pend      = 1'b0; // R9
         next_hold_op   = next_stg_op;
         next_hold_freq = next_stg_freq;
         if (img_len_i != fpm_pkg::LEN_EXT2) begin
            next_hold_trq = next_stg_trq;
         end
      end
      if (clear_cmd_i && !comm[fpm_pkg::F_CLR]) begin
         next_hold_op   = 16'h0000; // R3
         next_hold_freq = 16'h0000;
         next_hold_trq  = 16'h0000;
         next_stg_op    = 16'h0000;
         next_stg_freq  = 16'h0000;
         next_stg_trq   = 16'h0000;
         next_pend      = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rx_idx      <= 5'h00;
         stg_op      <= 16'h0000;
         stg_freq    <= 16'h0000;
         stg_trq     <= 16'h0000;
         pend        <= 1'b0;
         wait_cnt    <= 18'h00000;
         hold_op     <= 16'h0000;
         hold_freq   <= 16'h0000;
         hold_trq    <= 16'h0000;
         msg_valid_o <= 1'b0;
         msg_idx_o   <= 4'h0;
         msg_byte_o  <= 8'h00;
      end else begin
         rx_idx      <= next_rx_idx;
         stg_op      <= next_stg_op;
         stg_freq    <= next_stg_freq;
         stg_trq     <= next_stg_trq;
         pend        <= next_pend;
         wait_cnt    <= next_wait;
         hold_op     <= next_hold_op;
         hold_freq   <= next_hold_freq;
         hold_trq    <= next_hold_trq;
         msg_valid_o <= next_msg_valid;
         msg_idx_o   <= next_msg_idx;
         msg_byte_o  <= rx_byte_i;
      end
   end

   // gating of network words toward the drive
   assign trq_use = (cm == fpm_pkg::CM_CLV || cm == fpm_pkg::CM_AOLVPM || cm == fpm_pkg::CM_CLVPM) &&
                    comm[fpm_pkg::F_TEN]; // R13
   assign trq_lim = !drv[fpm_pkg::F_TF] || (cm == fpm_pkg::CM_CLVPM); // R13
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         op_cmd_o        <= 16'h0000;
         net_run_en_o    <= 1'b0;
         freq_ref_o      <= 16'h0000;
         net_freq_en_o   <= 1'b0;
         torque_ref_o    <= 16'h0000;
         torque_ref_en_o <= 1'b0;
         torque_lim_o    <= 16'h0000;
         torque_lim_en_o <= 1'b0;
      end else begin
         net_run_en_o    <= drv[fpm_pkg::F_RN +: 3] == fpm_pkg::SRC_NET; // R16
         op_cmd_o        <= (drv[fpm_pkg::F_RN +: 3] == fpm_pkg::SRC_NET) ? hold_op : 16'h0000;
         net_freq_en_o   <= drv[fpm_pkg::F_RF +: 3] == fpm_pkg::SRC_NET; // R16
         freq_ref_o      <= (drv[fpm_pkg::F_RF +: 3] == fpm_pkg::SRC_NET) ? hold_freq : 16'h0000;
         torque_ref_en_o <= trq_use && !trq_lim;
         torque_ref_o    <= (trq_use && !trq_lim) ? hold_trq : 16'h0000;
         torque_lim_en_o <= trq_use && trq_lim;
         torque_lim_o    <= (trq_use && trq_lim) ? hold_trq : 16'h0000;
      end
   end

   // reply bytes for register messages
   always_ff @(posedge clk_i) begin
      if (rsp_we_i) begin
         rsp_mem[rsp_idx_i] <= rsp_byte_i;
      end
   end

   // input image byte selection
   assign spd_word = drv[fpm_pkg::F_DSP] ? speed_user_i : speed_freq_i; // R15
   assign cur_word = drive_large_i ? current_i / fpm_pkg::CUR_DIV : current_i; // R14
   assign tx_rel   = tx_idx_i - msg_off;
   always_comb begin
      next_tx = 8'h00; // R19
      if (tx_rd_i && tx_idx_i <= last_of(img_len_i) && img_len_i != 2'h3 && act_map) begin
         if (tx_idx_i[4:1] == fpm_pkg::B_OP[4:1]) begin
            next_tx = pick(drive_status_i, tx_idx_i[0]); // R12
         end else if (tx_idx_i[4:1] == fpm_pkg::B_FREQ[4:1]) begin
            next_tx = pick(spd_word, tx_idx_i[0]);
         end else if (img_len_i == fpm_pkg::LEN_BASIC && tx_idx_i[4:1] == fpm_pkg::B_TRQ[4:1]) begin
            next_tx = pick(cur_word, tx_idx_i[0]);
         end else if (img_len_i == fpm_pkg::LEN_EXT1 && tx_idx_i[4:1] == fpm_pkg::B_CUR1[4:1]) begin
            next_tx = pick(cur_word, tx_idx_i[0]);
         end else if (img_len_i != fpm_pkg::LEN_BASIC && tx_idx_i >= msg_off) begin
            next_tx = rsp_mem[tx_rel[3:0]]; // R8
         end
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tx_byte_o <= 8'h00;
      end else begin
         tx_byte_o <= next_tx;
      end
   end

   // stop responses to bus error and external fault
   fpm_fault_resp u_bus (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .evt_i    (bus_err_i),
      .method_i (drv[fpm_pkg::F_BER +: 2]),
      .clear_i  (fault_clr),
      .stop_o   (stop_b),
      .alarm_o  (alm_b),
      .mode_o   (mode_b)
   ); // R18
   fpm_fault_resp u_ext (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .evt_i    (ext_fault_i),
      .method_i (drv[fpm_pkg::F_EFS +: 2]),
      .clear_i  (fault_clr),
      .stop_o   (stop_e),
      .alarm_o  (alm_e),
      .mode_o   (mode_e)
   ); // R17

   // combined stop request, bus error mode first
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         stop_req_o  <= 1'b0;
         stop_mode_o <= 2'h0;
         alarm_o     <= 1'b0;
      end else begin
         stop_req_o  <= stop_b | stop_e;
         stop_mode_o <= stop_b ? mode_b : mode_e;
         alarm_o     <= alm_b | alm_e;
      end
   end
endmodule
`default_nettype wire

// File: inc/fpm_pkg.sv
package fpm_pkg;
   // timing
   localparam int unsigned CLK_HZ         = 100_000_000;
   localparam int unsigned FAST_LIMIT_US  = 2000;
   localparam int unsigned FAST_LIMIT_CYC = FAST_LIMIT_US * (CLK_HZ / 1_000_000);
   // image length codes from master configuration
   localparam logic [1:0] LEN_EXT1  = 2'h0;
   localparam logic [1:0] LEN_EXT2  = 2'h1;
   localparam logic [1:0] LEN_BASIC = 2'h2;
   // last byte index of each image, last fast byte, first message byte
   localparam logic [4:0] LAST_EXT1  = 5'h1f;
   localparam logic [4:0] LAST_EXT2  = 5'h0b;
   localparam logic [4:0] LAST_BASIC = 5'h05;
   localparam logic [4:0] FAST_EXT1  = 5'h0f;
   localparam logic [4:0] FAST_EXT2  = 5'h03;
   localparam logic [4:0] MSG_EXT1   = 5'h10;
   localparam logic [4:0] MSG_EXT2   = 5'h04;
   // byte positions inside images
   localparam logic [4:0] B_OP   = 5'h00;
   localparam logic [4:0] B_FREQ = 5'h02;
   localparam logic [4:0] B_TRQ  = 5'h04;
   localparam logic [4:0] B_CUR1 = 5'h0c;
   // register offsets
   localparam logic [7:0] A_COMM   = 8'h00;
   localparam logic [7:0] A_DRIVE  = 8'h01;
   localparam logic [7:0] A_CMD    = 8'h02;
   localparam logic [7:0] A_STAT   = 8'h03;
   localparam logic [7:0] A_MASK   = 8'h04;
   localparam logic [7:0] A_ACTIVE = 8'h05;
   // comm settings fields
   localparam int unsigned F_CLR  = 8;
   localparam int unsigned F_MAP  = 9;
   localparam int unsigned F_IDX  = 10;
   localparam int unsigned F_CRST = 11;
   localparam int unsigned F_TEN  = 12;
   // drive settings fields
   localparam int unsigned F_CM  = 0;
   localparam int unsigned F_TF  = 3;
   localparam int unsigned F_RF  = 4;
   localparam int unsigned F_RN  = 7;
   localparam int unsigned F_EFS = 10;
   localparam int unsigned F_BER = 12;
   localparam int unsigned F_DSP = 14;
   // reset values
   localparam logic [15:0] COMM_RST  = 16'h0000;
   localparam logic [15:0] DRIVE_RST = 16'h1400;
   // setting values
   localparam logic [6:0] ADDR_MAX  = 7'h7d;
   localparam logic [2:0] SRC_NET   = 3'h3;
   localparam logic [2:0] CM_CLV    = 3'h3;
   localparam logic [2:0] CM_AOLVPM = 3'h6;
   localparam logic [2:0] CM_CLVPM  = 3'h7;
   localparam logic [1:0] ACT_ALARM = 2'h3;
   localparam logic [15:0] CUR_DIV  = 16'h000a;
   // status bits
   localparam int unsigned S_FRAME = 0;
   localparam int unsigned S_LEN   = 1;
   localparam int unsigned S_CLEAR = 2;
   localparam int unsigned S_BUS   = 3;
   localparam int unsigned S_EXT   = 4;
   localparam int unsigned S_ADDR  = 5;
   localparam int unsigned S_W     = 6;
endpackage

// File: hw/fpm_fault_resp.sv
`timescale 1ns/1ps
`default_nettype none
module fpm_fault_resp (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   // event and response choice
   input  wire logic       evt_i,
   input  wire logic [1:0] method_i,
   input  wire logic       clear_i,
   // response
   output logic            stop_o,
   output logic            alarm_o,
   output logic [1:0]      mode_o
);
   logic       next_stop;
   logic       next_alarm;
   logic [1:0] next_mode;

   // alarm-only keeps running, other methods latch a stop
   always_comb begin
      next_stop  = stop_o;
      next_alarm = alarm_o;
      next_mode  = mode_o;
      if (clear_i) begin
         next_stop  = 1'b0;
         next_alarm = 1'b0;
      end
      if (evt_i) begin
         if (method_i == fpm_pkg::ACT_ALARM) begin
            next_alarm = 1'b1;
         end else if (!stop_o || clear_i) begin
            next_stop = 1'b1;
            next_mode = method_i;
         end
      end
   end

   // response state
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         stop_o  <= 1'b0;
         alarm_o <= 1'b0;
         mode_o  <= 2'h0;
      end else begin
         stop_o  <= next_stop;
         alarm_o <= next_alarm;
         mode_o  <= next_mode;
      end
   end
endmodule
`default_nettype wire

// File: verif/fpm_mapper_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module fpm_mapper_chk (
   // clock, reset, strobes
   input wire logic        clk_i, resetn_i, reg_re_i, tx_rd_i, rx_valid_i, ext_fault_i, bus_err_i,
   // watched outputs
   input wire logic        msg_valid_o, stop_req_o, alarm_o, net_run_en_o, net_freq_en_o,
   input wire logic        torque_ref_en_o, torque_lim_en_o,
   input wire logic [1:0]  stop_mode_o,
   input wire logic [7:0]  tx_byte_o,
   input wire logic [15:0] reg_rdata_o, op_cmd_o, freq_ref_o, torque_ref_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   // fault event at the response logic
   sequence s_evt;
      ext_fault_i || bus_err_i;
   endsequence
   a_rdata_idle: assert property (!reg_re_i |=> reg_rdata_o == 16'h0000)
      else $error("read data outside read slot");
   a_tx_idle: assert property (!tx_rd_i |=> tx_byte_o == 8'h00)
      else $error("input byte outside request slot");
   a_msg_cause: assert property (msg_valid_o |-> $past(rx_valid_i))
      else $error("message byte without received byte");
   a_evt_resp: assert property (s_evt |-> ##2 (stop_req_o || alarm_o))
      else $error("fault event without response");
   a_alarm_cause: assert property ($rose(alarm_o) |-> $past(ext_fault_i || bus_err_i, 2))
      else $error("alarm without event");
   a_mode_legal: assert property (stop_req_o |-> stop_mode_o != 2'h3)
      else $error("illegal stop mode");
   a_run_gate: assert property (!net_run_en_o |-> op_cmd_o == 16'h0000)
      else $error("command passed while gated");
   a_freq_gate: assert property (!net_freq_en_o |-> freq_ref_o == 16'h0000)
      else $error("reference passed while gated");
   a_trq_gate: assert property (!torque_ref_en_o |-> torque_ref_o == 16'h0000)
      else $error("torque passed while gated");
   a_trq_excl: assert property (!(torque_ref_en_o && torque_lim_en_o))
      else $error("torque both reference and limit");
endmodule
bind fpm_mapper fpm_mapper_chk chk_u (.*);
`default_nettype wire

// File: verif/fpm_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module fpm_master_model (
   // clock
   input  wire logic       clk_i,
   // image traffic
   output logic [1:0]      img_len_i,
   output logic            rx_valid_i, rx_last_i, clear_cmd_i, tx_rd_i,
   output logic [7:0]      rx_byte_i,
   output logic [4:0]      tx_idx_i,
   input  wire logic [7:0] tx_byte_o
);
   // idle bus at start
   initial begin
      {img_len_i, rx_valid_i, rx_last_i, clear_cmd_i, tx_rd_i, rx_byte_i, tx_idx_i} = '0;
   end
   // one output image, byte i carries base plus i
   task automatic send(input logic [1:0] len, input int n, input logic [7:0] base);
      img_len_i <= len;
      for (int i = 0; i < n; i++) begin
         @(posedge clk_i);
         rx_valid_i <= 1'b1;
         rx_byte_i  <= base + 8'(i);
         rx_last_i  <= (i == n - 1);
      end
      @(posedge clk_i);
      rx_valid_i <= 1'b0;
      rx_last_i  <= 1'b0;
      rx_byte_i  <= ~rx_byte_i;
      // held words reach the outputs one edge later
      @(posedge clk_i);
   endtask
   // one input image byte
   task automatic get(input logic [4:0] idx, output logic [7:0] b);
      @(posedge clk_i);
      tx_rd_i  <= 1'b1;
      tx_idx_i <= idx;
      @(posedge clk_i);
      tx_rd_i <= 1'b0;
      #1 b = tx_byte_o;
   endtask
   // bus clear command
   task automatic clr();
      @(posedge clk_i);
      clear_cmd_i <= 1'b1;
      @(posedge clk_i);
      clear_cmd_i <= 1'b0;
      @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        clk_i, resetn_i, reg_we_i, reg_re_i, power_up_i, rx_valid_i, rx_last_i, clear_cmd_i, tx_rd_i;
   logic        rsp_we_i, drive_large_i, ext_fault_i, bus_err_i, msg_valid_o, net_run_en_o, net_freq_en_o;
   logic        torque_ref_en_o, torque_lim_en_o, stop_req_o, alarm_o, err_led_o, irq_o;
   logic [1:0]  img_len_i, stop_mode_o;
   logic [3:0]  msg_idx_o, rsp_idx_i;
   logic [4:0]  tx_idx_i;
   logic [7:0]  reg_addr_i, rx_byte_i, tx_byte_o, msg_byte_o, rsp_byte_i, b;
   logic [15:0] reg_wdata_i, reg_rdata_o, op_cmd_o, freq_ref_o, torque_ref_o, torque_lim_o;
   logic [15:0] drive_status_i, speed_freq_i, speed_user_i, current_i;
   logic [6:0]  av [4] = '{7'h00, 7'h03, 7'h7d, 7'h7e};
   logic [3:0]  led = 4'b1001;
   logic [47:0] img = 48'ha1b2_0c0d_001d;
   int          err_count, n_tests, n_msg;
   fpm_mapper #(.FAST_LIMIT(20)) dut_u (.*);
   fpm_master_model m_u (.*);
   // clock
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // message byte counter
   always @(posedge clk_i) begin
      if (msg_valid_o === 1'b1) begin
         n_msg++;
         chk("msg", 16'(msg_byte_o), 16'(8'h44 + msg_idx_o));
      end
   end
   task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
      n_tests++;
      if (s !== e) begin
         err_count++;
         $display("unexpected %s exp %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [15:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_we_i <= 1'b1;
      @(posedge clk_i);
      reg_we_i <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, logic [15:0] e);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_re_i <= 1'b1;
      @(posedge clk_i);
      reg_re_i <= 1'b0;
      #1 chk("reg", reg_rdata_o, e);
   endtask
   // strobe, then settle
   task automatic pw(int w);
      @(posedge clk_i);
      power_up_i <= w[0];
      ext_fault_i <= w[1];
      bus_err_i <= w[2];
      @(posedge clk_i);
      {power_up_i, ext_fault_i, bus_err_i} <= '0;
      repeat (3) @(posedge clk_i);
      #1;
   endtask
   task automatic give_verdict();
      if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // watchdog
   initial begin
      repeat (5000) @(posedge clk_i);
      err_count++;
      give_verdict();
   end
   // main sequence
   initial begin
      {reg_we_i, reg_re_i, power_up_i, rsp_we_i, ext_fault_i, bus_err_i, reg_addr_i, reg_wdata_i} = '0;
      {rsp_idx_i, rsp_byte_i} = '0;
      drive_large_i = 1'b1;
      drive_status_i = 16'ha1b2;
      speed_freq_i = 16'h0c0d;
      speed_user_i = 16'h1234;
      current_i = 16'h0123;
      resetn_i = 1'b0;
      repeat (16) @(posedge clk_i);
      resetn_i <= 1'b1;
      rd(8'h00, 16'h0000);
      rd(8'h01, 16'h1400);
      rd(8'h3f, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         wr(8'h00, {9'h000, av[i]});
         chk("led held", 16'(err_led_o), 16'(i > 0 && led[i-1]));
         pw(1);
         chk("led", 16'(err_led_o), 16'(led[i]));
      end
      wr(8'h00, 16'h1003);
      wr(8'h01, 16'h1dbb);
      pw(1);
      m_u.send(2'h2, 6, 8'h11);
      chk("map off", op_cmd_o, 16'h0000);
      wr(8'h00, 16'h1203);
      pw(1);
      m_u.send(2'h2, 6, 8'h11);
      #1 chk("cmd", op_cmd_o, 16'h1112);
      chk("freq", freq_ref_o, 16'h1314);
      chk("tref", torque_ref_o, 16'h1516);
      wr(8'h01, 16'h1db3);
      m_u.send(2'h2, 6, 8'h21);
      #1 chk("tlim", torque_lim_o, 16'h2526);
      for (int i = 0; i < 6; i++) begin
         m_u.get(5'(i), b);
         chk("in byte", 16'(b), 16'(img[47-8*i -: 8]));
      end
      m_u.send(2'h1, 12, 8'h40);
      #1 chk("msgs", 16'(n_msg), 16'h0008);
      @(posedge clk_i);
      {rsp_we_i, rsp_idx_i, rsp_byte_i} <= {1'b1, 4'h0, 8'h5a};
      @(posedge clk_i);
      rsp_we_i <= 1'b0;
      m_u.get(5'h04, b);
      chk("reply", 16'(b), 16'h005a);
      wr(8'h00, 16'h1303);
      m_u.clr();
      #1 chk("hold", op_cmd_o, 16'h4041);
      wr(8'h00, 16'h1203);
      m_u.clr();
      #1 chk("clear", op_cmd_o, 16'h0000);
      wr(8'h03, 16'h007f);
      pw(2);
      chk("alarm", 16'({alarm_o, stop_req_o}), 16'h0002);
      pw(4);
      chk("stop", 16'({stop_req_o, stop_mode_o}), 16'h0005);
      wr(8'h04, 16'h0008);
      pw(0);
      chk("irq", 16'(irq_o), 16'h0001);
      wr(8'h03, 16'h0008);
      pw(0);
      chk("irq clr", 16'(irq_o), 16'h0000);
      rd(8'h03, 16'h0010);
      wr(8'h02, 16'h0003);
      rd(8'h00, 16'h1203);
      chk("fault clr", 16'({alarm_o, stop_req_o}), 16'h0000);
      wr(8'h00, 16'h1a03);
      wr(8'h02, 16'h0001);
      rd(8'h00, 16'h0000);
      rd(8'h01, 16'h1400);
      give_verdict();
   end
endmodule
`default_nettype wire
